// ---- rtl/recorder_defs.svh ----
`ifndef RECORDER_DEFS_SVH
`define RECORDER_DEFS_SVH
// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 10
`define BASE_PERIOD_NS 250000
// ****************************************
// Register byte offsets
// ****************************************
`define ADDR_BITS 7:0
`define OFF_MODE_CYCLE 8'h00
`define OFF_START 8'h04
`define OFF_TRIG_MODE 8'h08
`define OFF_AXIS_COMMON 8'h0C
`define OFF_TRIG_CHAN 8'h10
`define OFF_LEVEL1 8'h14
`define OFF_LEVEL2 8'h18
`define OFF_ALARM_SEL 8'h1C
`define OFF_CONTROL 8'h20
`define OFF_STATUS 8'h24
`define OFF_READ_SEL 8'h28
`define OFF_READ_DATA 8'h2C
`define OFF_READ_SERIAL 8'h30
// ****************************************
// Field positions
// ****************************************
`define F_MODE 0
`define F_CYCLE 15:8
`define F_START 1:0
`define F_TMODE 0
`define F_COMB 5:4
`define F_EDGE1 8
`define F_EDGE2 12
`define F_COMMON 0
`define F_CH1 7:0
`define F_CH2 15:8
`define F_POS 23:16
`define F_LEVEL 15:0
`define F_ALARM 7:0
`define F_CLEAR 0
`define F_RD_IDX 3:0
`define F_RD_SLOT 7:4
`define F_ST_SERIAL 13:0
`define F_ST_COUNT 20:16
`define F_ST_RUN 24
`define F_ST_ARMED 25
`define F_ST_COPY 26
`define F_ST_HEAD 31:28
// ****************************************
// Reset values and codes
// ****************************************
`define RST_CYCLE 8'h00
`define RST_CH1 8'h01
`define RST_CH2 8'h81
`define RST_POS 8'h5A
`define RST_LEVEL 16'h0000
`define RST_ALARM_SEL 8'h00
`define CYC_FIRST 8'h05
`define CYC_LAST 8'h11
`define START_STOP 2'h0
`define START_SINGLE 2'h1
`define START_CONT 2'h2
`define COMB_OFF 2'h0
`define COMB_AND 2'h1
`define COMB_OR 2'h2
`define CH_DIGITAL 7
`define CH_ANA2 2'h2
`define POS_FULL 8'h64
`define REC_LEN 16
`define HIST_DEPTH 16
`define SERIAL_WRAP 14'h270F
`endif

// ---- rtl/recorder_pkg.sv ----
package recorder_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FILL,
    ST_ARM,
    ST_POST,
    ST_COPY
  } rec_state_t;
  typedef logic [31:0] sample_t;
endpackage

// ---- rtl/drive_recorder.sv ----
`timescale 1ns/100ps
`include "recorder_defs.svh"
// Functional notes
// - An alarm captures a record into internal history for later readout.
// - Mode field: 0 automatic (reset default), 1 manual.
// - Automatic mode ignores sampling, trigger, channel settings; alarm only triggers.
// - Cycle code 00 means 250 us; 05..11 double from 250 us to 1.024 s.
// - Start field: 0 stop, 1 single capture, 2 continuous; manual mode only.
// - Cycle, trigger and channel writes are refused while manual sampling runs.
// - History keeps at most 16 records; the oldest is overwritten.
// - Clear-history command erases all stored records.
// - Each record gets a serial number counting 0 to 9999 then wrapping.
// - Trigger mode: 0 alarm trigger (default), 1 channel level trigger.
// - Combination: 0 disabled, 1 both triggers, 2 either trigger.
// - Trigger 1 fires rising above level (bit 0) or falling below (1).
// - Trigger 2 has its own rising or falling edge selection, coded the same way.
// - Common-axis bit 0 stores triggering axis only, 1 stores all axes when manual mode uses channel level trigger.
// - Trigger 1 channel defaults to 01h, analog channel 1.
// - Trigger 2 channel defaults to 81h, digital channel 1.
// - Trigger position is a percentage 0..100 of the window, default 5Ah.
// - Each trigger compares its channel against its own level, default zero.
module drive_recorder
  import recorder_pkg::*;
#(
  parameter int BASE_CYCLES = `BASE_PERIOD_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Drive signals
  input wire logic [11:0] ana1_in,
  input wire logic [11:0] ana2_in,
  input wire logic [7:0] dig_in,
  input wire logic alarm_in,
  input wire logic [7:0] alarm_code_in,
  // Multi-axis trigger sharing
  input wire logic common_trig_in,
  output logic axis_trig_out,
  output logic store_all_axes
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic signed [15:0] chan_val(input logic [7:0] code);
    logic [2:0] bit_idx;
    bit_idx = code[2:0] - 3'h1;
    if (code[`CH_DIGITAL]) begin
      chan_val = {15'h0000, dig_in[bit_idx]};
    end else if (code[1:0] == `CH_ANA2) begin
      chan_val = {{4{ana2_in[11]}}, ana2_in};
    end else begin
      chan_val = {{4{ana1_in[11]}}, ana1_in};
    end
  endfunction

  function automatic logic crossed(input logic signed [15:0] prev,
                                   input logic signed [15:0] cur,
                                   input logic signed [15:0] lvl,
                                   input logic falling);
    if (falling) begin
      crossed = (prev >= lvl) && (cur < lvl);
    end else begin
      crossed = (prev <= lvl) && (cur > lvl);
    end
  endfunction

  function automatic logic [4:0] pre_samples(input logic [7:0] pos);
    logic [10:0] scaled;
    logic [7:0] p;
    p = (pos > `POS_FULL) ? `POS_FULL : pos;
    scaled = 11'({p, 4'h0}) / 11'(`POS_FULL);
    // A full 100 % still leaves the trigger sample itself in the window
    pre_samples = (scaled >= 11'(`REC_LEN)) ? 5'(`REC_LEN - 1) : scaled[4:0];
  endfunction

  // ****************************************
  // Bus slave
  // ****************************************
  logic wr_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  logic take;
  logic lock;

  assign take = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_q <= take && hwrite;
      if (take) begin
        wr_addr_q <= haddr[`ADDR_BITS];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata_q <= rd_mux;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  logic mode_q;
  logic [7:0] cycle_q;
  logic [1:0] start_q;
  logic trig_mode_q;
  logic [1:0] comb_q;
  logic edge1_q;
  logic edge2_q;
  logic common_q;
  logic [7:0] ch1_q;
  logic [7:0] ch2_q;
  logic [7:0] pos_q;
  logic [15:0] lvl1_q;
  logic [15:0] lvl2_q;
  logic [7:0] alarm_sel_q;
  logic [7:0] rd_sel_q;
  logic single_done;
  logic clr_hist;

  // Settings freeze only while a manual run is active
  assign lock = mode_q && (start_q != `START_STOP);
  assign clr_hist = wr_q && (wr_addr_q == `OFF_CONTROL) && hwdata[`F_CLEAR];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= 1'b0;
      cycle_q <= `RST_CYCLE;
    end else if (wr_q && (wr_addr_q == `OFF_MODE_CYCLE)) begin
      mode_q <= hwdata[`F_MODE];
      if (!lock) begin
        cycle_q <= hwdata[`F_CYCLE];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_q <= `START_STOP;
    end else if (wr_q && (wr_addr_q == `OFF_START)) begin
      // Unused code 3 is taken as stop
      start_q <= (hwdata[`F_START] == 2'h3) ? `START_STOP : hwdata[`F_START];
    end else if (single_done) begin
      start_q <= `START_STOP;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_mode_q <= 1'b0;
      comb_q <= `COMB_OFF;
      edge1_q <= 1'b0;
      edge2_q <= 1'b0;
      common_q <= 1'b0;
      ch1_q <= `RST_CH1;
      ch2_q <= `RST_CH2;
      pos_q <= `RST_POS;
      lvl1_q <= `RST_LEVEL;
      lvl2_q <= `RST_LEVEL;
      alarm_sel_q <= `RST_ALARM_SEL;
    end else if (wr_q && !lock) begin
      case (wr_addr_q)
        `OFF_TRIG_MODE: begin
          trig_mode_q <= hwdata[`F_TMODE];
          comb_q <= hwdata[`F_COMB];
          edge1_q <= hwdata[`F_EDGE1];
          edge2_q <= hwdata[`F_EDGE2];
        end
        `OFF_AXIS_COMMON: common_q <= hwdata[`F_COMMON];
        `OFF_TRIG_CHAN: begin
          ch1_q <= hwdata[`F_CH1];
          ch2_q <= hwdata[`F_CH2];
          pos_q <= hwdata[`F_POS];
        end
        `OFF_LEVEL1: lvl1_q <= hwdata[`F_LEVEL];
        `OFF_LEVEL2: lvl2_q <= hwdata[`F_LEVEL];
        `OFF_ALARM_SEL: alarm_sel_q <= hwdata[`F_ALARM];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_sel_q <= 8'h00;
    end else if (wr_q && (wr_addr_q == `OFF_READ_SEL)) begin
      rd_sel_q <= hwdata[7:0];
    end
  end

  // ****************************************
  // Sample rate divider
  // ****************************************
  rec_state_t state_q;
  logic [31:0] base_cnt_q;
  logic [12:0] tick_cnt_q;
  logic [7:0] eff_cycle;
  logic [12:0] tick_limit;
  logic base_tick;
  logic samp_tick;
  logic run;

  assign run = !mode_q || (start_q != `START_STOP);
  // Automatic mode and undefined codes fall back to the 250 us base
  assign eff_cycle = (!mode_q || cycle_q < `CYC_FIRST || cycle_q > `CYC_LAST) ? `CYC_FIRST : cycle_q;
  assign tick_limit = 13'h0001 << (eff_cycle - `CYC_FIRST);
  assign base_tick = (base_cnt_q == 32'(BASE_CYCLES - 1));
  assign samp_tick = base_tick && (tick_cnt_q == tick_limit - 13'h0001);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_cnt_q <= 32'h00000000;
      tick_cnt_q <= 13'h0000;
    end else if (state_q == ST_IDLE) begin
      base_cnt_q <= 32'h00000000;
      tick_cnt_q <= 13'h0000;
    end else if (base_tick) begin
      base_cnt_q <= 32'h00000000;
      tick_cnt_q <= samp_tick ? 13'h0000 : tick_cnt_q + 13'h0001;
    end else begin
      base_cnt_q <= base_cnt_q + 32'h00000001;
    end
  end

  // ****************************************
  // Trigger evaluation
  // ****************************************
  logic signed [15:0] cur1;
  logic signed [15:0] cur2;
  logic signed [15:0] prev1_q;
  logic signed [15:0] prev2_q;
  logic prev_ok_q;
  logic alarm_d_q;
  logic alarm_pend_q;
  logic alarm_ev;
  logic hit1;
  logic hit2;
  logic level_fire;
  logic level_mode;
  logic fire;
  logic fire_take;

  assign cur1 = chan_val(ch1_q);
  assign cur2 = chan_val(ch2_q);
  assign hit1 = prev_ok_q && crossed(prev1_q, cur1, lvl1_q, edge1_q);
  assign hit2 = prev_ok_q && crossed(prev2_q, cur2, lvl2_q, edge2_q);
  assign level_mode = mode_q && trig_mode_q;
  assign alarm_ev = alarm_in && !alarm_d_q && (alarm_sel_q == `RST_ALARM_SEL || alarm_code_in == alarm_sel_q);

  always_comb begin
    case (comb_q)
      `COMB_AND: level_fire = hit1 && hit2;
      `COMB_OR: level_fire = hit1 || hit2;
      default: level_fire = hit1;
    endcase
  end

  // Another axis may trigger this one only when sharing is on
  assign fire = level_mode ? (level_fire || (common_q && common_trig_in)) : alarm_pend_q;
  assign fire_take = samp_tick && (state_q == ST_ARM) && fire;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev1_q <= 16'h0000;
      prev2_q <= 16'h0000;
      prev_ok_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      prev_ok_q <= 1'b0;
    end else if (samp_tick) begin
      prev1_q <= cur1;
      prev2_q <= cur2;
      prev_ok_q <= 1'b1;
    end
  end

  // A new alarm in the same cycle as consumption is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_d_q <= 1'b0;
      alarm_pend_q <= 1'b0;
    end else begin
      alarm_d_q <= alarm_in;
      if (alarm_ev) begin
        alarm_pend_q <= 1'b1;
      end else if (state_q == ST_IDLE || (fire_take && !level_mode)) begin
        alarm_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      axis_trig_out <= 1'b0;
      store_all_axes <= 1'b0;
    end else begin
      axis_trig_out <= fire_take && level_mode && common_q && level_fire;
      store_all_axes <= level_mode && common_q;
    end
  end

  // ****************************************
  // Capture and history
  // ****************************************
  sample_t ring [`REC_LEN];
  sample_t hist [`HIST_DEPTH][`REC_LEN];
  logic [13:0] slot_serial [`HIST_DEPTH];
  logic [3:0] wp_q;
  logic [4:0] fill_q;
  logic [4:0] post_q;
  logic [3:0] cp_q;
  logic [3:0] head_q;
  logic [4:0] count_q;
  logic [13:0] serial_q;
  logic [4:0] pre_len;
  logic ring_wr;
  logic copy_done;

  // Automatic mode uses the default trigger position
  assign pre_len = pre_samples(mode_q ? pos_q : `RST_POS);
  assign ring_wr = samp_tick && (state_q == ST_FILL || state_q == ST_ARM || state_q == ST_POST);
  assign copy_done = (state_q == ST_COPY) && (cp_q == 4'(`REC_LEN - 1));
  assign single_done = copy_done && mode_q && (start_q == `START_SINGLE);

  always_ff @(posedge hclk) begin
    if (ring_wr) begin
      ring[wp_q] <= {dig_in, ana1_in, ana2_in};
    end
  end

  always_ff @(posedge hclk) begin
    if (state_q == ST_COPY) begin
      // Oldest sample sits at the write pointer
      hist[head_q][cp_q] <= ring[wp_q + cp_q];
    end
    if (copy_done) begin
      slot_serial[head_q] <= serial_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      wp_q <= 4'h0;
      fill_q <= 5'h00;
      post_q <= 5'h00;
      cp_q <= 4'h0;
    end else if (!run) begin
      state_q <= ST_IDLE;
    end else begin
      if (ring_wr) begin
        wp_q <= wp_q + 4'h1;
      end
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_FILL;
          fill_q <= 5'h00;
        end
        ST_FILL: begin
          if (fill_q >= pre_len) begin
            state_q <= ST_ARM;
          end else if (samp_tick) begin
            fill_q <= fill_q + 5'h01;
          end
        end
        ST_ARM: begin
          if (fire_take) begin
            // Trigger sample counts as the first post-trigger sample
            post_q <= 5'(`REC_LEN - 1) - pre_len;
            state_q <= ST_POST;
          end
        end
        ST_POST: begin
          if (post_q == 5'h00) begin
            state_q <= ST_COPY;
            cp_q <= 4'h0;
          end else if (samp_tick) begin
            post_q <= post_q - 5'h01;
          end
        end
        ST_COPY: begin
          cp_q <= cp_q + 4'h1;
          if (copy_done) begin
            state_q <= single_done ? ST_IDLE : ST_FILL;
            fill_q <= 5'h00;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Clearing in the last copy cycle drops the record being stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      head_q <= 4'h0;
      count_q <= 5'h00;
    end else if (clr_hist) begin
      head_q <= 4'h0;
      count_q <= 5'h00;
    end else if (copy_done) begin
      head_q <= head_q + 4'h1;
      if (count_q != 5'(`HIST_DEPTH)) begin
        count_q <= count_q + 5'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_q <= 14'h0000;
    end else if (copy_done) begin
      serial_q <= (serial_q == `SERIAL_WRAP) ? 14'h0000 : serial_q + 14'h0001;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rd_mux = 32'h00000000;
    case (haddr[`ADDR_BITS])
      `OFF_MODE_CYCLE: begin
        rd_mux[`F_MODE] = mode_q;
        rd_mux[`F_CYCLE] = cycle_q;
      end
      `OFF_START: rd_mux[`F_START] = start_q;
      `OFF_TRIG_MODE: begin
        rd_mux[`F_TMODE] = trig_mode_q;
        rd_mux[`F_COMB] = comb_q;
        rd_mux[`F_EDGE1] = edge1_q;
        rd_mux[`F_EDGE2] = edge2_q;
      end
      `OFF_AXIS_COMMON: rd_mux[`F_COMMON] = common_q;
      `OFF_TRIG_CHAN: begin
        rd_mux[`F_CH1] = ch1_q;
        rd_mux[`F_CH2] = ch2_q;
        rd_mux[`F_POS] = pos_q;
      end
      `OFF_LEVEL1: rd_mux[`F_LEVEL] = lvl1_q;
      `OFF_LEVEL2: rd_mux[`F_LEVEL] = lvl2_q;
      `OFF_ALARM_SEL: rd_mux[`F_ALARM] = alarm_sel_q;
      `OFF_STATUS: begin
        rd_mux[`F_ST_SERIAL] = serial_q;
        rd_mux[`F_ST_COUNT] = count_q;
        rd_mux[`F_ST_RUN] = (state_q != ST_IDLE);
        rd_mux[`F_ST_ARMED] = (state_q == ST_ARM);
        rd_mux[`F_ST_COPY] = (state_q == ST_COPY);
        rd_mux[`F_ST_HEAD] = head_q;
      end
      `OFF_READ_SEL: rd_mux[7:0] = rd_sel_q;
      `OFF_READ_DATA: rd_mux = hist[rd_sel_q[`F_RD_SLOT]][rd_sel_q[`F_RD_IDX]];
      `OFF_READ_SERIAL: rd_mux[`F_ST_SERIAL] = slot_serial[rd_sel_q[`F_RD_SLOT]];
      default: rd_mux = 32'h00000000;
    endcase
  end

endmodule

// ---- test/recorder_assertions.sv ----
`timescale 1ns/100ps
module recorder_assertions #(
  parameter int BASE_CYCLES = 25000
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Drive signals
  input wire logic [11:0] ana1_in,
  input wire logic [11:0] ana2_in,
  input wire logic [7:0] dig_in,
  input wire logic alarm_in,
  input wire logic [7:0] alarm_code_in,
  // Multi-axis trigger sharing
  input wire logic common_trig_in,
  input wire logic axis_trig_out,
  input wire logic store_all_axes
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ****************************************
  // Bus phases
  // ****************************************
  sequence rd_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence mode_auto_write;
    (hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00) ##1 !hwdata[0];
  endsequence
  // ****************************************
  // Checks
  // ****************************************
  a_ready_high: assert property (hreadyout)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (!hresp)
    else $error("slave gave an error response");
  a_hrdata_reset: assert property ($rose(hresetn) |-> hrdata == 32'h0)
    else $error("read data not clear after reset");
  a_unmapped_zero: assert property (rd_taken ##0 (haddr[7:0] >= 8'h34) |=> hrdata == 32'h0)
    else $error("unmapped read returned data");
  a_start_narrow: assert property (rd_taken ##0 (haddr[7:0] == 8'h04) |=> hrdata[31:2] == 30'h0)
    else $error("start field read has stray bits");
  a_hrdata_stands: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  a_trig_single: assert property (axis_trig_out |=> !axis_trig_out)
    else $error("shared trigger pulse longer than one cycle");
  a_trig_shared: assert property (axis_trig_out |-> store_all_axes)
    else $error("shared trigger with sharing off");
  a_auto_no_share: assert property (mode_auto_write |-> ##[1:2] !store_all_axes)
    else $error("all-axes store kept in automatic mode");
endmodule
bind drive_recorder recorder_assertions #(.BASE_CYCLES(BASE_CYCLES)) i_recorder_assertions (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .ana1_in(ana1_in), .ana2_in(ana2_in), .dig_in(dig_in), .alarm_in(alarm_in),
  .alarm_code_in(alarm_code_in), .common_trig_in(common_trig_in), .axis_trig_out(axis_trig_out),
  .store_all_axes(store_all_axes)
);

// ---- test/drive_source.sv ----
`timescale 1ns/100ps
module drive_source (
  // Clock
  input wire logic hclk,
  // Drive signals toward the recorder
  output logic [11:0] ana1,
  output logic [11:0] ana2,
  output logic [7:0] dig,
  output logic alarm,
  output logic [7:0] alarm_code,
  output logic common_trig
);
  initial begin
    ana1 = 12'h000;
    ana2 = 12'h123;
    dig = 8'h01;
    alarm = 1'b0;
    alarm_code = 8'h00;
    common_trig = 1'b0;
  end
  // Second channel wanders so stored samples are never constant
  always @(posedge hclk) begin
    ana2 <= ana2 + 12'h001;
  end
  task set_lines(input logic [11:0] a, input logic [7:0] d);
    @(posedge hclk);
    ana1 <= a;
    dig <= d;
  endtask
  // Trigger shared by another axis, held as a level
  task set_common(input logic v);
    @(posedge hclk);
    common_trig <= v;
  endtask
  // Alarm is a level; only its rising edge counts as an event
  task pulse_alarm(input logic [7:0] code);
    @(posedge hclk);
    alarm <= 1'b1;
    alarm_code <= code;
    repeat (2) @(posedge hclk);
    alarm <= 1'b0;
  endtask
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/100ps
`include "recorder_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
  localparam logic [31:0] CNT = 32'h001F0000;
  localparam logic [31:0] ARMED = 32'h02000000;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, alarm, common_trig, axis_trig_out, store_all_axes;
  logic [31:0] hrdata, rd;
  logic [11:0] ana1, ana2;
  logic [7:0] dig, alarm_code;
  logic trig_seen = 1'b0;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  always #5 hclk = ~hclk;
  drive_recorder #(.BASE_CYCLES(4)) i_drive_recorder (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ana1_in(ana1), .ana2_in(ana2), .dig_in(dig), .alarm_in(alarm),
    .alarm_code_in(alarm_code), .common_trig_in(common_trig), .axis_trig_out(axis_trig_out),
    .store_all_axes(store_all_axes)
  );
  drive_source i_drive_source (
    .hclk(hclk), .ana1(ana1), .ana2(ana2), .dig(dig), .alarm(alarm), .alarm_code(alarm_code),
    .common_trig(common_trig)
  );
  always @(posedge hclk) begin
    if (axis_trig_out === 1'b1) trig_seen <= 1'b1;
  end
  // ****************************************
  // Bus master
  // ****************************************
  task bus_cycle(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task bus_write(input logic [7:0] a, input logic [31:0] d);
    bus_cycle(a, 1'b1, d);
  endtask
  task bus_read(input logic [7:0] a);
    bus_cycle(a, 1'b0, 32'h0);
  endtask
  // Bounded poll of the status word; a miss shows up as one mismatch
  task wait_field(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    bus_read(`OFF_STATUS);
    while ((rd & m) !== v && n < 300) begin
      bus_read(`OFF_STATUS);
      n++;
    end
    `CHK(rd & m, v)
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset_vals;
    bus_read(`OFF_MODE_CYCLE); `CHK(rd, 32'h0)
    bus_read(`OFF_START); `CHK(rd, 32'h0)
    bus_read(`OFF_TRIG_MODE); `CHK(rd, 32'h0)
    bus_read(`OFF_AXIS_COMMON); `CHK(rd, 32'h0)
    bus_read(`OFF_TRIG_CHAN); `CHK(rd, 32'h005A8101)
    bus_read(`OFF_LEVEL1); `CHK(rd, 32'h0)
    bus_read(`OFF_LEVEL2); `CHK(rd, 32'h0)
    bus_read(8'h40); `CHK(rd, 32'h0)
  endtask
  task t_auto_alarm;
    bus_write(`OFF_TRIG_MODE, 32'h1);
    wait_field(ARMED, ARMED);
    i_drive_source.set_lines(12'h0C8, 8'h01);
    repeat (40) @(posedge hclk);
    bus_read(`OFF_STATUS); `CHK(rd & CNT, 32'h0)
    i_drive_source.pulse_alarm(8'h21);
    wait_field(CNT, 32'h00010000);
    `CHK(rd[13:0], 14'h0001)
    i_drive_source.set_lines(12'h000, 8'h01);
  endtask
  task t_manual_and;
    bus_write(`OFF_MODE_CYCLE, 32'h0501);
    bus_read(`OFF_MODE_CYCLE); `CHK(rd, 32'h0501)
    bus_write(`OFF_TRIG_MODE, 32'h1011);
    bus_write(`OFF_LEVEL1, 32'h64);
    bus_write(`OFF_LEVEL2, 32'h1);
    bus_write(`OFF_AXIS_COMMON, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK(store_all_axes, 1'b1)
    bus_write(`OFF_START, 32'h1);
    wait_field(ARMED, ARMED);
    bus_write(`OFF_TRIG_CHAN, 32'h0);
    bus_read(`OFF_TRIG_CHAN); `CHK(rd, 32'h005A8101)
    i_drive_source.set_lines(12'h0C8, 8'h01);
    repeat (40) @(posedge hclk);
    bus_read(`OFF_STATUS); `CHK(rd & CNT, 32'h00010000)
    i_drive_source.set_lines(12'h000, 8'h01);
    repeat (12) @(posedge hclk);
    i_drive_source.set_lines(12'h0C8, 8'h00);
    wait_field(CNT, 32'h00020000);
    bus_read(`OFF_START); `CHK(rd, 32'h0)
    `CHK(trig_seen, 1'b1)
  endtask
  task t_or_cont;
    i_drive_source.set_lines(12'h000, 8'h01);
    bus_write(`OFF_TRIG_MODE, 32'h1021);
    bus_read(`OFF_TRIG_MODE); `CHK(rd, 32'h1021)
    bus_write(`OFF_START, 32'h2);
    wait_field(ARMED, ARMED);
    i_drive_source.set_lines(12'h000, 8'h00);
    wait_field(CNT, 32'h00030000);
    bus_read(`OFF_START); `CHK(rd, 32'h2)
    bus_write(`OFF_START, 32'h0);
  endtask
  task t_history;
    bus_write(`OFF_MODE_CYCLE, 32'h0);
    bus_write(`OFF_CONTROL, 32'h1);
    bus_read(`OFF_STATUS); `CHK(rd & 32'hF01F0000, 32'h0)
    `CHK(rd[13:0], 14'h0003)
    for (int i = 1; i <= 17; i++) begin
      i_drive_source.pulse_alarm(8'h30);
      wait_field(32'h3FFF, 32'd3 + i);
    end
    bus_read(`OFF_STATUS); `CHK(rd & 32'hF01F0000, 32'h10100000)
    bus_write(`OFF_READ_SEL, 32'h0);
    bus_read(`OFF_READ_SERIAL); `CHK(rd[13:0], 14'h0013)
  endtask
  // Channels stay quiet, so only the other axis can start this record
  task t_shared;
    bus_write(`OFF_MODE_CYCLE, 32'h0501);
    bus_write(`OFF_START, 32'h1);
    wait_field(ARMED, ARMED);
    i_drive_source.set_common(1'b1);
    wait_field(32'h3FFF, 32'h15);
    i_drive_source.set_common(1'b0);
    bus_read(`OFF_START); `CHK(rd, 32'h0)
  endtask
  // ****************************************
  // Verdict
  // ****************************************
  task wrap_up;
    if (bad_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Whole run needs a few thousand cycles; the ceiling leaves wide margin
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_vals;
    t_auto_alarm;
    t_manual_and;
    t_or_cont;
    t_history;
    t_shared;
    wrap_up;
  end
endmodule
